/* File: core/pls_pkg.sv */
// constants and types shared by the indicator and strap logic
// assumes a single 125 MHz system clock and a synchronous active-high reset
//
// Functional notes
// RL1 - duplex indicator low on full-duplex link, high in half-duplex
// RL2 - half-duplex collision drives duplex indicator low 80 ms, then high at least 80 ms
// RL3 - speed indicator low at 100 Mbps, high at 10 Mbps
// RL4 - link/activity indicator low while link up, high when link failed
// RL5 - activity while link up pulses link/activity indicator high for 80 ms
// RL6 - after each pulse indicator stays low at least 80 ms; new pulse needs new activity
// RL7 - serial ROM select and clock pins sampled as two-bit host bus type
// RL8 - device held in reset while reset pin is low
// RL9 - power-on settings including bus type captured at reset pin rising edge
// RL10 - test clock select makes the test clock the main timebase
// RL11 - first ROM word after reset must equal 5AA5h, else ROM absent
// RL12 - 80 ms intervals counted on 25 MHz local ticks, restarted at each boundary
package pls_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned LOCAL_HZ     = 25_000_000;
    localparam int unsigned LOCAL_DIV    = CLK_HZ / LOCAL_HZ;
    localparam int unsigned BLINK_MS     = 80;
    localparam int unsigned BLINK_TICKS  = (LOCAL_HZ / 1000) * BLINK_MS;

    // ----------------------------------------------------------------
    // values
    // ----------------------------------------------------------------
    localparam logic        LED_OFF       = 1'b1;
    localparam logic        LED_ON        = 1'b0;
    localparam logic [15:0] ROM_SIGNATURE = 16'h5aa5;
    localparam logic [1:0]  BUS_SRAM_LIKE = 2'h0;
    localparam logic [1:0]  BUS_EMB_16BIT = 2'h1;
    localparam logic [1:0]  BUS_RESERVED  = 2'h2;
    localparam logic [1:0]  BUS_MCU_8BIT  = 2'h3;
    localparam logic [1:0]  BUS_TYPE_RST  = BUS_SRAM_LIKE;

    typedef enum logic [1:0] {
        PLS_IDLE  = 2'b00,
        PLS_PULSE = 2'b01,
        PLS_GUARD = 2'b10
    } pls_blink_state_type;

endpackage : pls_pkg

/* File: core/pls_blinker.sv */
// one indicator blink sequencer: pulse phase then guard phase, each TICKS local ticks
// assumes tick_i is a one-cycle enable at the local clock rate
`timescale 1ns/10ps
module pls_blinker
    import pls_pkg::*;
#(
    parameter int unsigned TICKS = pls_pkg::BLINK_TICKS
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tick_i,
    input  wire logic enable_i,
    input  wire logic trigger_i,
    output logic      pulse_o,
    output logic      guard_o
);
    import pls_pkg::*;

    localparam int unsigned CW = $clog2(TICKS + 1);

    pls_blink_state_type state;
    pls_blink_state_type next_state;
    logic [CW-1:0]       cnt;
    logic [CW-1:0]       next_cnt;
    wire                 last_tick;

    assign last_tick = tick_i && (cnt == CW'(TICKS - 1));
    assign pulse_o   = (state == PLS_PULSE);
    assign guard_o   = (state == PLS_GUARD);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            PLS_IDLE: begin
                next_cnt = '0;
                if (enable_i && trigger_i) begin                    // RL6
                    next_state = PLS_PULSE;
                end
            end
            PLS_PULSE, PLS_GUARD: begin
                if (!enable_i) begin
                    next_state = PLS_IDLE;
                    next_cnt   = '0;
                end else if (last_tick) begin                       // RL12
                    next_state = (state == PLS_PULSE) ? PLS_GUARD : PLS_IDLE;
                    next_cnt   = '0;
                end else if (tick_i) begin
                    next_cnt = cnt + CW'(1);
                end
            end
            default: begin
                next_state = PLS_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= PLS_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

endmodule : pls_blinker

/* File: core/pls_top.sv */
// phy status indicators, bus type strap capture and serial ROM signature check
// assumes all pin inputs are synchronous to clk_i; indicators are active low
`timescale 1ns/10ps
module pls_top
    import pls_pkg::*;
#(
    parameter int unsigned BLINK_TICKS = pls_pkg::BLINK_TICKS
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       reset_n_pin_i,
    input  wire logic       test_clock_select_i,
    input  wire logic       test_clock_in_i,
    input  wire logic       link_up_i,
    input  wire logic       full_duplex_i,
    input  wire logic       speed_100_i,
    input  wire logic       collision_i,
    input  wire logic       tx_activity_i,
    input  wire logic       rx_activity_i,
    input  wire logic       serial_rom_select_i,
    input  wire logic       serial_rom_clock_i,
    input  wire logic [15:0] rom_word_i,
    input  wire logic       rom_word_valid_i,
    output logic            duplex_collision_led_o,
    output logic            speed_led_o,
    output logic            link_activity_led_o,
    output logic [1:0]      bus_type_o,
    output logic            rom_present_o,
    output logic            rom_checked_o,
    output logic            device_reset_o
);
    import pls_pkg::*;

    localparam int unsigned HW = $clog2(BLINK_TICKS + 2);
    localparam int unsigned DW = $clog2(LOCAL_DIV);

    // ----------------------------------------------------------------
    // reset and strap capture
    // ----------------------------------------------------------------
    logic reset_n_q;
    wire  pin_rise;

    assign pin_rise = reset_n_pin_i && !reset_n_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reset_n_q      <= 1'b1;
            bus_type_o     <= BUS_TYPE_RST;
            device_reset_o <= 1'b1;
        end else begin
            reset_n_q      <= reset_n_pin_i;
            device_reset_o <= !reset_n_pin_i;                       // RL8
            if (pin_rise) begin
                bus_type_o <= {serial_rom_select_i, serial_rom_clock_i}; // RL7 RL9
            end
        end
    end

    wire core_rst;
    assign core_rst = sys_rst_i || device_reset_o;

    // ----------------------------------------------------------------
    // local timebase
    // ----------------------------------------------------------------
    logic [DW-1:0] div_cnt;
    logic          test_clock_in_q;
    logic          local_tick;
    wire           div_tick;
    wire           test_clock_in_rise;
    wire           next_tick;

    assign div_tick  = (div_cnt == DW'(LOCAL_DIV - 1));
    assign test_clock_in_rise = test_clock_in_i && !test_clock_in_q;
    assign next_tick = test_clock_select_i ? test_clock_in_rise : div_tick;  // RL10

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_cnt    <= '0;
            test_clock_in_q     <= 1'b0;
            local_tick <= 1'b0;
        end else begin
            div_cnt    <= div_tick ? '0 : div_cnt + DW'(1);         // RL12
            test_clock_in_q     <= test_clock_in_i;
            local_tick <= next_tick;
        end
    end

    // ----------------------------------------------------------------
    // blink sequencers
    // ----------------------------------------------------------------
    logic coll_pulse;
    logic coll_guard;
    logic act_pulse;
    logic act_guard;
    wire  half_duplex_link;
    wire  activity;

    assign half_duplex_link = link_up_i && !full_duplex_i;
    assign activity         = tx_activity_i || rx_activity_i;

    pls_blinker #(
        .TICKS     (BLINK_TICKS)
    ) u_coll_blink (
        .clk_i     (clk_i),
        .rst_i     (core_rst),
        .tick_i    (local_tick),
        .enable_i  (half_duplex_link),
        .trigger_i (collision_i),                                   // RL2
        .pulse_o   (coll_pulse),
        .guard_o   (coll_guard)
    );

    pls_blinker #(
        .TICKS     (BLINK_TICKS)
    ) u_act_blink (
        .clk_i     (clk_i),
        .rst_i     (core_rst),
        .tick_i    (local_tick),
        .enable_i  (link_up_i),
        .trigger_i (activity),                                      // RL5
        .pulse_o   (act_pulse),
        .guard_o   (act_guard)
    );

    // ----------------------------------------------------------------
    // indicator outputs
    // ----------------------------------------------------------------
    wire next_duplex_led;
    wire next_speed_led;
    wire next_act_led;

    assign next_duplex_led = (link_up_i && full_duplex_i) ? LED_ON
                           : (coll_pulse ? LED_ON : LED_OFF);       // RL1 RL2
    assign next_speed_led  = speed_100_i ? LED_ON : LED_OFF;        // RL3
    assign next_act_led    = (!link_up_i || act_pulse) ? LED_OFF : LED_ON; // RL4 RL5 RL6

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            duplex_collision_led_o <= LED_OFF;
            speed_led_o            <= LED_OFF;
            link_activity_led_o    <= LED_OFF;
        end else begin
            duplex_collision_led_o <= next_duplex_led;
            speed_led_o            <= next_speed_led;
            link_activity_led_o    <= next_act_led;
        end
    end

    // ----------------------------------------------------------------
    // serial ROM signature check
    // ----------------------------------------------------------------
    wire first_word;
    assign first_word = rom_word_valid_i && !rom_checked_o;

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            rom_checked_o <= 1'b0;
            rom_present_o <= 1'b0;
        end else if (first_word) begin
            rom_checked_o <= 1'b1;
            rom_present_o <= (rom_word_i == ROM_SIGNATURE);         // RL11
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [HW-1:0] coll_len;
    logic [HW-1:0] act_len;
    logic [HW-1:0] guard_len;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            coll_len  <= '0;
            act_len   <= '0;
            guard_len <= '0;
        end else begin
            coll_len  <= !coll_pulse ? '0 : coll_len + HW'(local_tick);
            act_len   <= !act_pulse ? '0 : act_len + HW'(local_tick);
            guard_len <= !act_guard ? '0 : guard_len + HW'(local_tick);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence div_period_s;
        !div_tick [*4] ##1 div_tick;
    endsequence

    full_duplex_a: assert property (                                // RL1
        (link_up_i && full_duplex_i && !core_rst) |=> (duplex_collision_led_o == LED_ON))
        else $error("duplex indicator not on for full duplex link");

    coll_len_a: assert property (                                   // RL2
        ($fell(coll_pulse) && coll_guard) |-> (coll_len == HW'(BLINK_TICKS)))
        else $error("collision blink length wrong");

    speed_led_a: assert property (                                  // RL3
        !core_rst |=> (speed_led_o == !$past(speed_100_i)))
        else $error("speed indicator wrong");

    link_down_a: assert property (                                  // RL4
        (!link_up_i && !core_rst) |=> (link_activity_led_o == LED_OFF))
        else $error("link indicator lit without link");

    act_pulse_a: assert property (                                  // RL5
        ($fell(act_pulse) && act_guard) |-> (act_len == HW'(BLINK_TICKS)))
        else $error("activity blink length wrong");

    act_guard_a: assert property (                                  // RL6
        ($fell(act_guard) && $past(link_up_i) && !$past(core_rst)) |-> (guard_len == HW'(BLINK_TICKS)))
        else $error("activity guard length wrong");

    act_start_a: assert property (                                  // RL6
        $rose(act_pulse) |-> $past(activity && link_up_i))
        else $error("activity blink without activity");

    strap_cap_a: assert property (                                  // RL7
        pin_rise |=> (bus_type_o == $past({serial_rom_select_i, serial_rom_clock_i})))
        else $error("bus type strap not captured at reset release");

    pin_reset_a: assert property (                                  // RL8
        !reset_n_pin_i |=> device_reset_o ##1 (!act_pulse && (link_activity_led_o == LED_OFF)))
        else $error("device not held in reset");

    test_tick_a: assert property (                                  // RL10
        (test_clock_select_i && test_clock_in_rise) |=> local_tick)
        else $error("test clock edge gave no tick");

    rom_sig_a: assert property (                                    // RL11
        (first_word && !core_rst) |=> (rom_checked_o && (rom_present_o == ($past(rom_word_i) == ROM_SIGNATURE))))
        else $error("rom signature decision wrong");

    div_rate_a: assert property (                                   // RL12
        div_tick |=> div_period_s)
        else $error("local tick divider period wrong");

endmodule : pls_top

/* File: dv/pls_strap_model.sv */
// board strap resistors on the serial ROM select and clock pins
// assumes the bench drives the strap only around the reset pin rise
`timescale 1ns/10ps
module pls_strap_model (
    input  wire logic       drive_i,
    input  wire logic [1:0] code_i,
    output logic            serial_rom_select_o,
    output logic            serial_rom_clock_o
);
    // released pins fall to their pull-down level
    assign serial_rom_select_o = drive_i ? code_i[1] : 1'b0;
    assign serial_rom_clock_o  = drive_i ? code_i[0] : 1'b0;
endmodule : pls_strap_model

/* File: dv/pls_top_bench.sv */
// self-checking bench for the indicator, strap and ROM signature logic
// assumes a 125 MHz clock and a blink length shrunk to 4 local ticks
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module pls_top_bench;
    import pls_pkg::*;
    localparam int unsigned BT = 4;
    logic        clk_i = 0, sys_rst_i = 1, reset_n_pin_i = 1, test_clock_select_i = 0, test_clock_in_i = 0;
    logic        link_up_i = 0, full_duplex_i = 0, speed_100_i = 0, collision_i = 0;
    logic        tx_activity_i = 0, rx_activity_i = 0, strap_drive = 0, rom_word_valid_i = 0;
    logic [1:0]  strap_code = 2'h0;
    logic [15:0] rom_word_i = 16'h0000;
    logic        sel_w, ck_w, dup_led, spd_led, lnk_led, rom_present, rom_checked, dev_rst;
    logic [1:0]  bus_type;
    int          fail_count = 0, checks = 0, w1, w2, w3, k;
    integer      seed = 32'hbf77_d3e5;

    pls_top #(.BLINK_TICKS(BT)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_n_pin_i(reset_n_pin_i),
        .test_clock_select_i(test_clock_select_i), .test_clock_in_i(test_clock_in_i),
        .link_up_i(link_up_i), .full_duplex_i(full_duplex_i), .speed_100_i(speed_100_i),
        .collision_i(collision_i), .tx_activity_i(tx_activity_i), .rx_activity_i(rx_activity_i),
        .serial_rom_select_i(sel_w), .serial_rom_clock_i(ck_w), .rom_word_i(rom_word_i),
        .rom_word_valid_i(rom_word_valid_i), .duplex_collision_led_o(dup_led), .speed_led_o(spd_led),
        .link_activity_led_o(lnk_led), .bus_type_o(bus_type), .rom_present_o(rom_present),
        .rom_checked_o(rom_checked), .device_reset_o(dev_rst));
    pls_strap_model i_strap (.drive_i(strap_drive), .code_i(strap_code),
        .serial_rom_select_o(sel_w), .serial_rom_clock_o(ck_w));

    always #4 clk_i = ~clk_i;

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    // test clock rises every 20 system cycles
    always begin
        step(10);
        test_clock_in_i = ~test_clock_in_i;
    end

    function automatic logic led(input int s);
        return s ? lnk_led : dup_led;
    endfunction : led

    // wait for the level, then count how long it stays
    task automatic span(input int s, input logic lv, input int lim, output int w);
        int n;
        n = 0;
        w = 0;
        while (led(s) !== lv && n < lim) begin
            step(1);
            n++;
        end
        while (led(s) === lv && w < lim) begin
            step(1);
            w++;
        end
    endtask : span

    task automatic complete_run;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(8 * 20000);
        fail_count++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        step(20);
        `CHK("rst_leds", 3'b111, {dup_led, spd_led, lnk_led})
        `CHK("rst_bus_type", BUS_TYPE_RST, bus_type)
        sys_rst_i = 0;
        for (k = 0; k < 4; k++) begin
            reset_n_pin_i = 0;
            strap_drive = 1;
            strap_code = k[1:0];
            link_up_i = 1;
            step(3);
            `CHK("device_reset", 1'b1, dev_rst)
            `CHK("led_in_reset", LED_OFF, lnk_led)
            reset_n_pin_i = 1;
            step(2);
            strap_drive = 0;
            `CHK("bus_type", k[1:0], bus_type)
            `CHK("reset_off", 1'b0, dev_rst)
            `CHK("rom_unchecked", 1'b0, rom_checked)
            w1 = $random(seed);
            rom_word_i = (k == 2) ? ROM_SIGNATURE : ROM_SIGNATURE ^ (w1[15:0] | 16'h0001);
            rom_word_valid_i = 1;
            step(1);
            rom_word_i = (k == 2) ? 16'h0000 : ROM_SIGNATURE;
            step(1);
            rom_word_valid_i = 0;
            step(1);
            `CHK("rom_checked", 1'b1, rom_checked)
            `CHK("rom_present", k == 2, rom_present)
            `CHK("strap_stands", k[1:0], bus_type)
        end
        repeat (24) begin
            w1 = $random(seed);
            {link_up_i, full_duplex_i, speed_100_i} = w1[2:0];
            step(3);
            `CHK("speed_led", !speed_100_i, spd_led)
            `CHK("link_led", !link_up_i, lnk_led)
            `CHK("duplex_led", !(link_up_i && full_duplex_i), dup_led)
        end
        link_up_i = 1;
        full_duplex_i = 1;
        step(4);
        tx_activity_i = 1;
        span(1, 1'b1, 200, w1);
        span(1, 1'b0, 200, w2);
        span(1, 1'b1, 200, w3);
        tx_activity_i = 0;
        `CHK("act_pulse", 1'b1, w1 >= 16 && w1 <= 21)
        `CHK("act_gap", 1'b1, w2 >= 16 && w2 <= 24)
        span(1, 1'b0, 60, w1);
        `CHK("act_no_retrigger", 60, w1)
        rx_activity_i = 1;
        step(1);
        rx_activity_i = 0;
        step(1);
        `CHK("act_start", LED_OFF, lnk_led)
        step(60);
        full_duplex_i = 0;
        collision_i = 1;
        // half duplex shows the off level for a cycle before the blink starts
        span(0, 1'b1, 200, w3);
        `CHK("col_half_off", 1'b1, w3 >= 1 && w3 <= 2)
        span(0, 1'b0, 200, w1);
        span(0, 1'b1, 200, w2);
        `CHK("col_low", 1'b1, w1 >= 16 && w1 <= 21)
        `CHK("col_high", 1'b1, w2 >= 16 && w2 <= 24)
        full_duplex_i = 1;
        step(3);
        `CHK("fdx_col_led", LED_ON, dup_led)
        collision_i = 0;
        step(60);
        test_clock_select_i = 1;
        tx_activity_i = 1;
        step(1);
        tx_activity_i = 0;
        span(1, 1'b1, 200, w1);
        `CHK("test_clock_pulse", 1'b1, w1 >= 60 && w1 <= 82)
        complete_run();
    end
endmodule : pls_top_bench
